// ===== hdl/dma_seq_pkg.sv
package dma_seq_pkg;

  // ---------------------------------------------------------------
  // operating-mode codes of the control word
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_INVALID = 3'h0;
  localparam logic [2:0] MODE_BASIC = 3'h1;
  localparam logic [2:0] MODE_AUTO = 3'h2;
  localparam logic [2:0] MODE_PINGPONG = 3'h3;
  localparam logic [2:0] MODE_MSG_PRI = 3'h4;
  localparam logic [2:0] MODE_MSG_ALT = 3'h5;
  localparam logic [2:0] MODE_PSG_PRI = 3'h6;
  localparam logic [2:0] MODE_PSG_ALT = 3'h7;

  // ---------------------------------------------------------------
  // control word field positions
  // ---------------------------------------------------------------
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 2;
  localparam int NM1_LSB = 4;
  localparam int NM1_MSB = 13;
  localparam int RPOW_LSB = 14;
  localparam int RPOW_MSB = 17;

  // ---------------------------------------------------------------
  // counts and reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] RPOW_NO_ARB = 4'hA;
  localparam logic [10:0] MAX_XFERS = 11'h400;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // ---------------------------------------------------------------
  // sequencer states, gray along the usual path except FINISH back to IDLE
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_EVAL = 3'b011,
    ST_MOVE = 3'b010,
    ST_WBACK = 3'b110,
    ST_FINISH = 3'b111
  } seq_state_t;

endpackage

// ===== hdl/dma_prio_arb.sv
`timescale 1ns/1ps
module dma_prio_arb import dma_seq_pkg::*; #(
  parameter int N = 4
) (
  input wire logic [N-1:0] pend, // requesting channels
  output logic any_req, // at least one request
  output logic [$clog2(N)-1:0] grant // lowest index wins
);

  // ---------------------------------------------------------------
  // fixed priority, channel 0 highest
  // ---------------------------------------------------------------
  always_comb begin
    any_req = |pend;
    grant = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pend[i]) begin
        grant = i[$clog2(N)-1:0];
      end
    end
  end

endmodule

// ===== hdl/dma_slice_cnt.sv
`timescale 1ns/1ps
module dma_slice_cnt import dma_seq_pkg::*; (
  input wire logic mclk, // system clock
  input wire logic srst, // sync reset
  input wire logic clr, // restart slice count
  input wire logic inc, // one transfer done
  input wire logic [3:0] rpow, // arbitration exponent
  input wire logic [9:0] nm1, // count minus one
  input wire logic one_shot, // single-transfer slice
  output logic [10:0] cnt_q, // transfers in this slice
  output logic slice_end, // inc closes the slice
  output logic all_end // inc closes the whole count
);

  logic [10:0] arb_lim;
  logic [10:0] rem;
  logic [10:0] lim;
  logic [10:0] nxt;

  // ---------------------------------------------------------------
  // slice limit: min(2^R, remaining), or one
  // ---------------------------------------------------------------
  always_comb begin
    arb_lim = (rpow >= RPOW_NO_ARB) ? MAX_XFERS : (11'h001 << rpow);
    rem = {1'b0, nm1} + 11'h001;
    lim = (arb_lim < rem) ? arb_lim : rem;
    if (one_shot) begin
      lim = 11'h001;
    end
    nxt = cnt_q + 11'h001;
    slice_end = inc && (nxt == lim);
    all_end = slice_end && (nxt == rem);
  end

  // transfer counter within the slice
  always_ff @(posedge mclk) begin
    if (srst || clr) begin
      cnt_q <= 11'h000;
    end else if (inc) begin
      cnt_q <= nxt;
    end
  end

endmodule

// ===== hdl/dma_cycle_mode_sequencer.sv
// Overview of operation
// R1: finished channel gets invalid mode written back
// R2: invalid code fetched ends ping-pong/scatter-gather
// R3: basic uses either structure, starts on request
// R4: basic re-arbitrates each slice, needs request
// R5: basic pulses completion after full count
// R6: auto starts on request; single request stops
// R7: auto continues without request, completes after count
// R8: ping-pong alternates primary and alternate tasks
// R9: ping-pong stops on invalid or disabled channel
// R10: ping-pong pulses completion after every task
// R11: software rewrites only the idle structure
// R12: basic code ends a ping-pong sequence
// R13: software sets global and channel enables first
// R14: scatter-gather primary copies four words to alternate
// R15: scatter-gather self-runs until invalid/basic, then interrupt
// R16: primary word uses fixed size, increment, exponent
// R17: primary count is four transfers per task
// R18: exhausted primary gets invalid mode written
// R19: each copy and task raises internal request
// R20: basic final task pulses completion, ends chain
// R21: software stores task list before enabling channel
// R22: three-bit mode field encoding
// R23: exponent codes 1010 and up disable arbitration
// R24: count field holds transfers minus one
// R25: completion is one-cycle pulse per channel
`timescale 1ns/1ps
module dma_cycle_mode_sequencer import dma_seq_pkg::*; #(
  parameter int N = 4
) (
  input wire logic mclk, // system clock
  input wire logic srst, // sync reset
  input wire logic master_enable, // controller_config global enable
  input wire logic [N-1:0] channel_enable_set, // per-channel enable
  input wire logic [N-1:0] burst_req, // peripheral burst requests
  input wire logic [N-1:0] single_req, // peripheral single requests
  output logic ctl_rd_q, // control word read request
  output logic ctl_wr_q, // control word write request
  output logic [$clog2(N)-1:0] ctl_chan_q, // channel of word access
  output logic ctl_alt_q, // 1 = alternate structure
  output logic [31:0] ctl_wdata_q, // control word to write back
  input wire logic [31:0] ctl_rdata, // fetched control word
  input wire logic ctl_ack, // word access done
  output logic beat_req_q, // request one data transfer
  input wire logic beat_ack, // data transfer done
  output logic [N-1:0] done_pulse_q, // completion pulses
  output logic busy_q // sequencer not idle
);

  localparam int CW = $clog2(N);

  seq_state_t state_q;
  logic [CW-1:0] chan_q;
  logic alt_q;
  logic [31:0] word_q;
  logic one_shot_q;
  logic done_all_q;
  logic [N-1:0] alt_sel_q;
  logic [N-1:0] self_pend_q;
  logic [N-1:0] sg_chain_q;
  logic [N-1:0] pend;
  logic arb_any;
  logic [CW-1:0] arb_grant;
  logic [10:0] cnt_q;
  logic slice_end;
  logic all_end;
  logic [2:0] mode;
  logic mode_bad;
  logic [9:0] nm1_left;
  logic fin;

  // ---------------------------------------------------------------
  // arbitration and slice counting
  // ---------------------------------------------------------------

  // channels eligible to win the next arbitration
  assign pend = {N{master_enable}} & channel_enable_set & (burst_req | single_req | self_pend_q); // [R9] [R13]

  dma_prio_arb #(.N(N)) u_arb (
    .pend(pend),
    .any_req(arb_any),
    .grant(arb_grant)
  );

  dma_slice_cnt u_cnt (
    .mclk(mclk),
    .srst(srst),
    .clr(state_q == ST_EVAL),
    .inc(state_q == ST_MOVE && beat_ack),
    .rpow(word_q[RPOW_MSB:RPOW_LSB]), // [R23]
    .nm1(word_q[NM1_MSB:NM1_LSB]), // [R24]
    .one_shot(one_shot_q),
    .cnt_q(cnt_q),
    .slice_end(slice_end),
    .all_end(all_end)
  );

  // decoded view of the fetched word
  assign mode = word_q[MODE_MSB:MODE_LSB];
  assign mode_bad = (mode == MODE_INVALID) || (mode == MODE_PSG_PRI) || (mode == MODE_PSG_ALT); // [R22]
  assign nm1_left = word_q[NM1_MSB:NM1_LSB] - cnt_q[9:0] - 10'h001;
  assign fin = (state_q == ST_FINISH);

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------

  // state walk: pick, fetch, evaluate, move, write back, decide
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (arb_any) begin
            state_q <= ST_FETCH; // [R3] [R6]
          end
        end
        ST_FETCH: begin
          if (ctl_ack) begin
            state_q <= ST_EVAL;
          end
        end
        ST_EVAL: begin
          state_q <= mode_bad ? ST_FINISH : ST_MOVE; // [R2]
        end
        ST_MOVE: begin
          if (slice_end) begin
            state_q <= ST_WBACK;
          end
        end
        ST_WBACK: begin
          if (ctl_ack) begin
            state_q <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          state_q <= ST_IDLE; // [R4] [R10]
        end
      endcase
    end
  end

  // winner capture at arbitration
  always_ff @(posedge mclk) begin
    if (srst) begin
      chan_q <= '0;
      alt_q <= 1'b0;
      one_shot_q <= 1'b0;
    end else if (state_q == ST_IDLE && arb_any) begin
      chan_q <= arb_grant;
      alt_q <= alt_sel_q[arb_grant]; // [R3]
      one_shot_q <= single_req[arb_grant] & ~burst_req[arb_grant] & ~self_pend_q[arb_grant]; // [R6]
    end
  end

  // control word fetch
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctl_rd_q <= 1'b0;
      word_q <= WORD_RST;
    end else if (state_q == ST_IDLE && arb_any) begin
      ctl_rd_q <= 1'b1;
    end else if (state_q == ST_FETCH && ctl_ack) begin
      ctl_rd_q <= 1'b0;
      word_q <= ctl_rdata;
    end
  end

  // word access address
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctl_chan_q <= '0;
      ctl_alt_q <= 1'b0;
    end else if (state_q == ST_IDLE && arb_any) begin
      ctl_chan_q <= arb_grant;
      ctl_alt_q <= alt_sel_q[arb_grant];
    end
  end

  // data transfer requests
  always_ff @(posedge mclk) begin
    if (srst) begin
      beat_req_q <= 1'b0;
    end else if (state_q == ST_EVAL && !mode_bad) begin
      beat_req_q <= 1'b1;
    end else if (slice_end) begin
      beat_req_q <= 1'b0;
    end
  end

  // write back remaining count, or invalid mode when exhausted
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctl_wr_q <= 1'b0;
      ctl_wdata_q <= WORD_RST;
      done_all_q <= 1'b0;
    end else if (slice_end) begin
      ctl_wr_q <= 1'b1;
      done_all_q <= all_end;
      if (all_end) begin
        ctl_wdata_q <= {word_q[31:NM1_MSB+1], 10'h000, word_q[3], MODE_INVALID}; // [R1] [R18]
      end else begin
        ctl_wdata_q <= {word_q[31:NM1_MSB+1], nm1_left, word_q[3:0]};
      end
    end else if (state_q == ST_WBACK && ctl_ack) begin
      ctl_wr_q <= 1'b0;
    end else if (state_q == ST_EVAL) begin
      done_all_q <= 1'b0;
    end
  end

  // busy flag
  always_ff @(posedge mclk) begin
    if (srst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_q != ST_IDLE) || arb_any;
    end
  end

  // ---------------------------------------------------------------
  // per-channel mode state
  // ---------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_chan
    logic me;
    assign me = fin && (chan_q == CW'(i));

    // next structure, internal request, chain flag, completion
    always_ff @(posedge mclk) begin
      if (srst) begin
        alt_sel_q[i] <= 1'b0;
        self_pend_q[i] <= 1'b0;
        sg_chain_q[i] <= 1'b0;
        done_pulse_q[i] <= 1'b0;
      end else begin
        done_pulse_q[i] <= 1'b0; // [R25]
        if (me && mode_bad) begin
          alt_sel_q[i] <= 1'b0; // [R2] [R9]
          self_pend_q[i] <= 1'b0;
          sg_chain_q[i] <= 1'b0;
          done_pulse_q[i] <= sg_chain_q[i]; // [R15]
        end else if (me && !alt_q && mode == MODE_MSG_PRI) begin
          alt_sel_q[i] <= 1'b1; // [R14]
          self_pend_q[i] <= 1'b1; // [R19]
          sg_chain_q[i] <= 1'b1;
        end else if (me && alt_q && sg_chain_q[i]) begin
          if (!done_all_q) begin
            self_pend_q[i] <= 1'b1; // [R15]
          end else if (mode == MODE_BASIC) begin
            done_pulse_q[i] <= 1'b1; // [R20]
            alt_sel_q[i] <= 1'b0;
            self_pend_q[i] <= 1'b0;
            sg_chain_q[i] <= 1'b0;
          end else begin
            alt_sel_q[i] <= 1'b0; // [R19]
            self_pend_q[i] <= 1'b1;
          end
        end else if (me && mode == MODE_PINGPONG) begin
          if (done_all_q) begin
            done_pulse_q[i] <= 1'b1; // [R10]
            alt_sel_q[i] <= ~alt_q; // [R8]
          end
        end else if (me) begin
          if (done_all_q) begin
            done_pulse_q[i] <= 1'b1; // [R5] [R7] [R12]
            self_pend_q[i] <= 1'b0;
          end else begin
            self_pend_q[i] <= (mode == MODE_AUTO) && !one_shot_q; // [R4] [R6] [R7]
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  property p_inv_wb;
    ctl_wr_q && done_all_q |-> ctl_wdata_q[MODE_MSB:MODE_LSB] == MODE_INVALID && ctl_wdata_q[NM1_MSB:NM1_LSB] == 10'h000;
  endproperty
  a_inv_wb: assert property (p_inv_wb) else $error("exhausted word not invalidated"); // [R1]

  property p_inv_stop;
    state_q == ST_EVAL && mode_bad |=> state_q == ST_FINISH && !beat_req_q ##1 state_q == ST_IDLE;
  endproperty
  a_inv_stop: assert property (p_inv_stop) else $error("invalid code did not end operation"); // [R2]

  property p_start;
    state_q == ST_IDLE && arb_any |=> ctl_rd_q && state_q == ST_FETCH && !beat_req_q;
  endproperty
  a_start: assert property (p_start) else $error("request did not start a fetch"); // [R3]

  property p_pulse;
    |done_pulse_q |=> ~|done_pulse_q;
  endproperty
  a_pulse: assert property (p_pulse) else $error("completion longer than one cycle"); // [R25]

  property p_basic_done;
    fin && mode == MODE_BASIC && done_all_q && !sg_chain_q[chan_q] |=> done_pulse_q[chan_q];
  endproperty
  a_basic_done: assert property (p_basic_done) else $error("basic completion missing"); // [R5]

  property p_pp_flip;
    fin && mode == MODE_PINGPONG && done_all_q |=> alt_sel_q[chan_q] == !alt_q && done_pulse_q[chan_q];
  endproperty
  a_pp_flip: assert property (p_pp_flip) else $error("ping-pong did not switch structure"); // [R8]

  property p_sg_copy;
    fin && !alt_q && mode == MODE_MSG_PRI |=> alt_sel_q[chan_q] && self_pend_q[chan_q] && sg_chain_q[chan_q];
  endproperty
  a_sg_copy: assert property (p_sg_copy) else $error("copy did not hand over to alternate"); // [R14]

  property p_cnt_left;
    ctl_wr_q && !done_all_q |-> ctl_wdata_q[NM1_MSB:NM1_LSB] < word_q[NM1_MSB:NM1_LSB];
  endproperty
  a_cnt_left: assert property (p_cnt_left) else $error("remaining count not reduced"); // [R24]

  property p_sg_end;
    fin && alt_q && sg_chain_q[chan_q] && mode == MODE_BASIC && done_all_q |=> done_pulse_q[chan_q] && !sg_chain_q[chan_q];
  endproperty
  a_sg_end: assert property (p_sg_end) else $error("chain end not signalled"); // [R20]

  property p_slice_cap;
    state_q == ST_MOVE && word_q[RPOW_MSB:RPOW_LSB] < RPOW_NO_ARB |-> cnt_q < (11'h001 << word_q[RPOW_MSB:RPOW_LSB]);
  endproperty
  a_slice_cap: assert property (p_slice_cap) else $error("slice ran past arbitration boundary"); // [R4]

  property p_one_shot;
    state_q == ST_MOVE && one_shot_q |-> cnt_q == 11'h000;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("single request moved more than one"); // [R6]

  // main scenarios reached
  c_sg_copy: cover property (fin && !alt_q && mode == MODE_MSG_PRI);
  c_one_shot: cover property (fin && one_shot_q && mode == MODE_AUTO);
  c_pingpong: cover property (fin && mode == MODE_PINGPONG && done_all_q);
  c_sg_chain_end: cover property (fin && alt_q && sg_chain_q[chan_q] && mode == MODE_BASIC && done_all_q);
  c_auto_slice: cover property (fin && mode == MODE_AUTO && !done_all_q);

endmodule

// ===== tb/dma_mem_model.sv
`timescale 1ns/1ps
module dma_mem_model import dma_seq_pkg::*; (
  input wire logic mclk, // system clock
  input wire logic srst, // sync reset
  input wire logic slow, // insert wait states
  input wire logic ctl_rd_q, // word read
  input wire logic ctl_wr_q, // word write
  input wire logic [1:0] ctl_chan_q, // channel
  input wire logic ctl_alt_q, // structure
  input wire logic [31:0] ctl_wdata_q, // word to store
  output logic [31:0] ctl_rdata, // fetched word
  output logic ctl_ack, // access done
  input wire logic beat_req_q, // transfer wanted
  output logic beat_ack // transfer done
);
  logic [31:0] mem [4][2]; // control words
  logic [31:0] tasks [$]; // task list of a chain
  logic [1:0] wait_q;
  logic [1:0] pace_q;

  // ----------------------------------------
  // control word port
  // ----------------------------------------
  // one ack pulse per access, stale data inverted
  always @(posedge mclk) begin
    ctl_ack <= 1'b0;
    ctl_rdata <= ~ctl_rdata;
    pace_q <= srst ? 2'h0 : pace_q + 2'h1;
    if (srst) begin
      wait_q <= 2'h0;
      ctl_rdata <= 32'h0;
    end else if ((ctl_rd_q || ctl_wr_q) && !ctl_ack) begin
      wait_q <= wait_q + 2'h1;
      if (!slow || wait_q == 2'h3) begin
        ctl_ack <= 1'b1;
        wait_q <= 2'h0;
        if (ctl_rd_q) begin
          ctl_rdata <= mem[ctl_chan_q][ctl_alt_q];
        end else begin
          mem[ctl_chan_q][ctl_alt_q] <= ctl_wdata_q;
        end
        // a copy slice brings the next task word
        if (ctl_wr_q && !ctl_alt_q && mem[ctl_chan_q][0][2:0] == MODE_MSG_PRI && tasks.size() > 0) begin
          mem[ctl_chan_q][1] <= tasks.pop_front();
        end
      end
    end
  end

  // ----------------------------------------
  // data transfers
  // ----------------------------------------
  // steady or halting pace
  assign beat_ack = beat_req_q && (!slow || pace_q[0]);
endmodule

// ===== tb/test_dma_cycle_mode_sequencer.sv
`timescale 1ns/1ps
module test_dma_cycle_mode_sequencer import dma_seq_pkg::*; ;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic master_enable = 1'b0;
  logic [3:0] channel_enable_set = 4'h0;
  logic [3:0] burst_req = 4'h0;
  logic [3:0] single_req = 4'h0;
  logic slow = 1'b0;
  logic ctl_rd_q, ctl_wr_q, ctl_alt_q, ctl_ack, beat_req_q, beat_ack, busy_q;
  logic [1:0] ctl_chan_q;
  logic [31:0] ctl_wdata_q, ctl_rdata;
  logic [3:0] done_pulse_q;
  logic [31:0] rnd = 32'h5948_5E11;
  int failures = 0;
  int comparisons = 0;
  int beats = 0;
  int dones = 0;
  int cycles = 0;
  int order [$];

  always #2 mclk = ~mclk;

  dma_cycle_mode_sequencer #(.N(4)) u_dut (.mclk(mclk), .srst(srst), .master_enable(master_enable),
    .channel_enable_set(channel_enable_set), .burst_req(burst_req), .single_req(single_req),
    .ctl_rd_q(ctl_rd_q), .ctl_wr_q(ctl_wr_q), .ctl_chan_q(ctl_chan_q), .ctl_alt_q(ctl_alt_q),
    .ctl_wdata_q(ctl_wdata_q), .ctl_rdata(ctl_rdata), .ctl_ack(ctl_ack), .beat_req_q(beat_req_q),
    .beat_ack(beat_ack), .done_pulse_q(done_pulse_q), .busy_q(busy_q));

  dma_mem_model u_mem (.mclk(mclk), .srst(srst), .slow(slow), .ctl_rd_q(ctl_rd_q), .ctl_wr_q(ctl_wr_q),
    .ctl_chan_q(ctl_chan_q), .ctl_alt_q(ctl_alt_q), .ctl_wdata_q(ctl_wdata_q), .ctl_rdata(ctl_rdata),
    .ctl_ack(ctl_ack), .beat_req_q(beat_req_q), .beat_ack(beat_ack));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] wd(logic [2:0] m, logic [9:0] n, logic [3:0] r);
    return {14'h0, r, n, 1'b0, m};
  endfunction

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // request, drop once taken unless held, await work
  task automatic go(int ch, logic b, logic s, logic hold, int eb, int ed);
    beats = 0;
    dones = 0;
    order.delete();
    burst_req[ch] = b;
    single_req[ch] = s;
    for (int t = 0; t < 3000 && (t < 8 || beats < eb || dones < ed); t++) begin
      @(negedge mclk);
      if (!hold && ctl_rd_q && ctl_chan_q == ch) begin
        burst_req = 4'h0;
        single_req = 4'h0;
      end
    end
    burst_req = 4'h0;
    single_req = 4'h0;
    repeat (40) @(negedge mclk);
    if (eb >= 0) check("transfers", eb, beats);
    check("completions", ed, dones);
    check("busy", 0, busy_q);
  endtask

  // count transfers and completions, cut a hang short
  always @(posedge mclk) begin
    cycles++;
    if (beat_req_q && beat_ack) beats++;
    for (int i = 0; i < 4; i++) begin
      if (done_pulse_q[i] === 1'b1) begin
        dones++;
        order.push_back(i);
      end
    end
    if (cycles == 30000) begin
      failures++;
      test_done();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (12) @(negedge mclk);
    srst = 1'b0;
    channel_enable_set = 4'hF;
    u_mem.mem[1][0] = wd(MODE_BASIC, 10'h5, 4'h1);
    go(1, 1, 0, 1, 0, 0);
    master_enable = 1'b1;
    go(1, 1, 0, 1, 6, 1);
    check("basic word", 14'h0, u_mem.mem[1][0][13:0]);
    u_mem.mem[2][0] = wd(MODE_BASIC, 10'h3, 4'h2);
    go(2, 0, 1, 1, 4, 1);
    u_mem.mem[2][0] = wd(MODE_AUTO, 10'h9, 4'h1);
    go(2, 1, 0, 0, 10, 1);
    check("auto word", 14'h0, u_mem.mem[2][0][13:0]);
    u_mem.mem[3][0] = wd(MODE_AUTO, 10'h3, 4'h3);
    go(3, 0, 1, 0, 1, 0);
    check("stopped word", wd(MODE_AUTO, 10'h2, 4'h3), u_mem.mem[3][0]);
    // higher-priority channel cuts in
    u_mem.mem[3][0] = wd(MODE_AUTO, 10'hF, 4'h0);
    u_mem.mem[0][0] = wd(MODE_BASIC, 10'h1, 4'h1);
    burst_req[3] = 1'b1;
    repeat (20) @(negedge mclk);
    go(0, 1, 0, 0, -1, 2);
    check("first done", 0, order[0]);
    check("second done", 3, order[1]);
    // disabled channel never starts
    channel_enable_set = 4'hD;
    u_mem.mem[1][0] = wd(MODE_PINGPONG, 10'h1, 4'h0);
    go(1, 1, 0, 1, 0, 0);
    channel_enable_set = 4'hF;
    // ping-pong, structures set while idle
    for (int k = 0; k < 2; k++) begin
      u_mem.mem[1][0] = k ? wd(MODE_PINGPONG, 10'h1, 4'h0) : wd(MODE_PINGPONG, 10'h5, 4'h2);
      u_mem.mem[1][1] = k ? wd(MODE_INVALID, 10'h0, 4'h0) : wd(MODE_BASIC, 10'h2, 4'h0);
      go(1, 1, 0, 1, k ? 2 : 9, k ? 1 : 2);
      check("ping-pong modes", 0, {u_mem.mem[1][0][2:0], u_mem.mem[1][1][2:0]});
    end
    // memory scatter/gather, last task basic
    u_mem.tasks = '{wd(MODE_MSG_ALT, 10'h2, 4'h2), wd(MODE_BASIC, 10'h3, 4'h2)};
    u_mem.mem[0][0] = wd(MODE_MSG_PRI, 10'h7, 4'h2) | 32'hAA00_0000;
    go(0, 1, 0, 0, 15, 1);
    check("chain modes", 0, {u_mem.mem[0][0][2:0], u_mem.mem[0][1][2:0]});
    // random basic and automatic runs, memory halting at times
    for (int k = 0; k < 12; k++) begin
      rnd = lfsr(rnd);
      slow = rnd[0];
      u_mem.mem[rnd[2:1]][0] = wd(rnd[3] ? MODE_AUTO : MODE_BASIC, {6'h0, rnd[7:4]}, rnd[11:8]);
      go(rnd[2:1], 1, 0, !rnd[3], rnd[7:4] + 1, 1);
      check("word", 14'h0, u_mem.mem[rnd[2:1]][0][13:0]);
    end
    test_done();
  end
endmodule
